/* port_write_capture_regs_tb.sv */
/*
  Self-checking bench for the port-write capture register group.
  Assumes the zero-wait APB slave and the link model in pwc_link_model.sv.
*/
module port_write_capture_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] BLK = 6'h01;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [3:0]            pstrb;
  logic                  pw_in_valid, pw_out_req, pw_out_valid, irq, tick_out, er;
  pwc_pkg::pwc_payload_t pw_in_payload, pl;
  pwc_pkg::pwc_port_idx_t pw_out_port;
  logic [7:0]            pnum;
  logic [7:0]            pv [4];
  int                    err_total, tests_run, seed, n;

  pwc_regs #(.SWITCH_BLOCK(BLK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pw_in_valid(pw_in_valid), .pw_in_payload(pw_in_payload), .pw_out_req(pw_out_req),
    .pw_out_port(pw_out_port), .pw_out_valid(pw_out_valid), .pw_out_port_number(pnum),
    .notify_in_irq_out(irq), .tick_out(tick_out));
  pwc_link_model link_u (.pclk(pclk), .pw_in_valid(pw_in_valid), .pw_in_payload(pw_in_payload),
    .pw_out_req(pw_out_req), .pw_out_port(pw_out_port));

  // free-running 100 MHz clock
  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb transfer; waits for pready, never assumes a wait count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_pnum(input int i);
    return {24'h0, BLK, i[1:0]};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    seed  = 53;
    pv    = '{8'h00, 8'h09, 8'h18, 8'h00};  // 100 and 250 MHz settings
    pv[3] = 8'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pwc_pkg::OFS_TICK_DIVIDER_VALUE, 0);
    chk(rd, 32'h0000000F);
    apb(0, pwc_pkg::OFS_NOTIFY_CTL, 0);
    chk(rd, 32'h0);
    $display("test reset values done");
    // reserved bits get random junk; tick period must be value plus one
    foreach (pv[i]) begin
      apb(1, pwc_pkg::OFS_TICK_DIVIDER_VALUE, (32'($random(seed)) & 32'hFFFFFF00) | {24'h0, pv[i]});
      apb(0, pwc_pkg::OFS_TICK_DIVIDER_VALUE, 0);
      chk(rd, {24'h0, pv[i]});
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (tick_out !== 1'b1 && n < 600);
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (tick_out !== 1'b1 && n < 600);
      chk(32'(n), 32'(pv[i]) + 1);
    end
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1, pwc_pkg::OFS_TICK_DIVIDER_VALUE, 32'h33);
    pstrb <= 4'hF;
    apb(0, pwc_pkg::OFS_TICK_DIVIDER_VALUE, 0);
    chk(rd, {24'h0, pv[3]});
    $display("test prescaler done");
    // port numbers: registers read-only, outgoing requests match them
    for (int i = 0; i < 4; i++) begin
      apb(1, pwc_pkg::OFS_PORTNUM_BASE + 12'(4 * i), 32'hFFFFFFFF);
      chk(32'(er), 32'h0);
      apb(0, pwc_pkg::OFS_PORTNUM_BASE + 12'(4 * i), 0);
      chk(rd, exp_pnum(i));
      link_u.ask_port(2'(i));
      @(negedge pclk);
      chk(32'(pw_out_valid), 32'h1);
      chk(32'(pnum), exp_pnum(i));
      @(negedge pclk);
      chk(32'(pw_out_valid), 32'h0);
    end
    $display("test port numbers done");
    // two payloads with interrupt disabled; the second overwrites the first
    repeat (2) begin
      for (int w = 0; w < 4; w++) pl[w] = 32'($random(seed));
      link_u.send_pw(pl);
      @(negedge pclk);
      chk(32'(irq), 32'h0);
      for (int w = 0; w < 4; w++) begin
        apb(0, pwc_pkg::OFS_CAPT_BASE + 12'(4 * w), 0);
        chk(rd, pl[w]);
      end
      apb(0, pwc_pkg::OFS_NOTIFY_CTL, 0);
      chk(rd, 32'h1);
    end
    apb(1, pwc_pkg::OFS_CAPT_BASE, ~pl[0]);
    apb(0, pwc_pkg::OFS_CAPT_BASE, 0);
    chk(rd, pl[0]);
    apb(1, pwc_pkg::OFS_NOTIFY_CTL, 32'h2);
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(0, pwc_pkg::OFS_NOTIFY_CTL, 0);
    chk(rd, 32'h3);
    apb(1, pwc_pkg::OFS_NOTIFY_CTL, 32'hFFFFFFFF);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(0, pwc_pkg::OFS_NOTIFY_CTL, 0);
    chk(rd, 32'h2);
    // payload with the interrupt enabled, then a clear that meets a new payload
    for (int w = 0; w < 4; w++) pl[w] = 32'($random(seed));
    link_u.send_pw(pl);
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    fork
      apb(1, pwc_pkg::OFS_NOTIFY_CTL, 32'h3);
      begin
        @(posedge pclk);
        link_u.send_pw(~pl);
      end
    join
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(0, pwc_pkg::OFS_CAPT_BASE + 12'h00C, 0);
    chk(rd, ~pl[3]);
    apb(1, pwc_pkg::OFS_NOTIFY_CTL, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(0, pwc_pkg::OFS_NOTIFY_CTL, 0);
    chk(rd, 32'h0);
    $display("test capture and flag done");
    // unmapped address is refused with read data zero
    apb(0, 12'h100, 0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    give_verdict();
  end
endmodule

/* pwc_link_model.sv */
/*
  Link-side model: delivers received port-write payloads and asks for outgoing
  port numbers, one-cycle strobes on pclk.
  Assumes the caller is the bench and that pclk runs free.
*/
module pwc_link_model (
  input  wire logic              pclk,
  output logic                   pw_in_valid,
  output pwc_pkg::pwc_payload_t  pw_in_payload,
  output logic                   pw_out_req,
  output pwc_pkg::pwc_port_idx_t pw_out_port
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle until the bench asks for traffic
  initial begin
    pw_in_valid   = 1'b0;
    pw_in_payload = '0;
    pw_out_req    = 1'b0;
    pw_out_port   = 2'h0;
  end

  // one payload pulse; word n travels in element n
  task automatic send_pw(input pwc_pkg::pwc_payload_t p);
    @(posedge pclk);
    pw_in_valid   <= 1'b1;
    pw_in_payload <= p;
    @(posedge pclk);
    pw_in_valid   <= 1'b0;
    pw_in_payload <= ~p;  // released lines show the inverse so stale sampling fails
  endtask

  // one port number request
  task automatic ask_port(input pwc_pkg::pwc_port_idx_t idx);
    @(posedge pclk);
    pw_out_req  <= 1'b1;
    pw_out_port <= idx;
    @(posedge pclk);
    pw_out_req  <= 1'b0;
    pw_out_port <= ~idx;
  endtask
endmodule

/* pwc_pkg.sv */
/*
  Package for the port-write capture register group: register byte offsets,
  field positions, reset values and shared types.
  Assumes a 32-bit APB slave with 12-bit byte addresses and one word per register.
*/
package pwc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_PORTS = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TICK_DIVIDER_VALUE     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_NOTIFY_CTL   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CAPT_BASE    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_PORTNUM_BASE = 12'h020;

  // a bank of four word registers spans 16 bytes
  localparam logic [ADDR_W-1:0] BANK_MASK = 12'hFF0;
  localparam int unsigned       IDX_LSB   = 2;
  localparam int unsigned       IDX_MSB   = 3;

  // field layout
  localparam int unsigned TICK_DIVIDER_VALUE_MSB = 7;
  localparam int unsigned FLAG_BIT     = 0;
  localparam int unsigned EN_BIT       = 1;
  localparam int unsigned PORTNUM_MSB  = 7;
  localparam int unsigned BLOCK_W      = 6;

  // reset values
  localparam logic [7:0]        TICK_DIVIDER_VALUE_RST = 8'h0F;
  localparam logic [DATA_W-1:0] WORD_ZERO    = 32'h0000_0000;
  localparam logic [7:0]        BYTE_ZERO    = 8'h00;

  typedef logic [DATA_W-1:0]                pwc_word_t;
  typedef logic [NUM_PORTS-1:0][DATA_W-1:0] pwc_payload_t;
  typedef logic [1:0]                       pwc_port_idx_t;

endpackage

/* pwc_regs.sv */
/*
  Port-write capture register group as an APB slave: tick prescaler, notify
  control/status, four payload capture words and four port number registers.
  Builds the port number for outgoing port-write requests.
  Assumes the link logic presents a received payload with a one-cycle valid and
  requests outgoing port numbers with a one-cycle strobe, all on pclk.
  Limitation: port numbers are fixed per instance through SWITCH_BLOCK, so two
  instances in one switch must be given different blocks.
*/
module pwc_regs #(
  parameter logic [5:0] SWITCH_BLOCK = 6'h00
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [pwc_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [pwc_pkg::DATA_W-1:0]      pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [pwc_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            pw_in_valid,
  input  wire pwc_pkg::pwc_payload_t           pw_in_payload,
  input  wire logic                            pw_out_req,
  input  wire pwc_pkg::pwc_port_idx_t          pw_out_port,
  output logic                                 pw_out_valid,
  output logic      [7:0]                      pw_out_port_number,
  output logic                                 notify_in_irq_out,
  output logic                                 tick_out
);

  typedef struct packed {
    logic [7:0]            tick_divider_value;
    logic                  notify_in_flag;
    logic                  notify_in_irq_enable;
    pwc_pkg::pwc_payload_t notify_payload_word;
    pwc_pkg::pwc_word_t    rd_data;
    logic                  rd_err;
    logic                  out_valid;
    logic [7:0]            out_number;
  } pwc_regs_state_t;

  pwc_regs_state_t st;
  pwc_regs_state_t next_st;

  logic setup_phase;
  logic apb_write;
  logic ctl_write;
  logic flag_clear;

  pwc_tick_if tif ();

  // true when the address is word-aligned and falls inside a four-word bank at the given base
  function automatic logic in_bank(input logic [pwc_pkg::ADDR_W-1:0] addr,
                                   input logic [pwc_pkg::ADDR_W-1:0] base);
    in_bank = ((addr & pwc_pkg::BANK_MASK) == base) && (addr[pwc_pkg::IDX_LSB-1:0] == '0);
  endfunction

  // word index inside a bank
  function automatic pwc_pkg::pwc_port_idx_t bank_idx(input logic [pwc_pkg::ADDR_W-1:0] addr);
    bank_idx = addr[pwc_pkg::IDX_MSB:pwc_pkg::IDX_LSB];
  endfunction

  // fabric connection number: block in the high bits, port in the low two
  function automatic logic [7:0] switch_port_number(input pwc_pkg::pwc_port_idx_t idx);
    switch_port_number = {SWITCH_BLOCK, idx};
  endfunction

  // read mux; every reserved bit is forced to zero here
  function automatic pwc_pkg::pwc_word_t read_word(input logic [pwc_pkg::ADDR_W-1:0] addr,
                                                   input pwc_regs_state_t s);
    read_word = pwc_pkg::WORD_ZERO;
    if (addr == pwc_pkg::OFS_TICK_DIVIDER_VALUE) begin
      read_word[pwc_pkg::TICK_DIVIDER_VALUE_MSB:0] = s.tick_divider_value;
    end else if (addr == pwc_pkg::OFS_NOTIFY_CTL) begin
      read_word[pwc_pkg::FLAG_BIT] = s.notify_in_flag;
      read_word[pwc_pkg::EN_BIT]   = s.notify_in_irq_enable;
    end else if (in_bank(addr, pwc_pkg::OFS_CAPT_BASE)) begin
      read_word = s.notify_payload_word[bank_idx(addr)];
    end else if (in_bank(addr, pwc_pkg::OFS_PORTNUM_BASE)) begin
      read_word[pwc_pkg::PORTNUM_MSB:0] = switch_port_number(bank_idx(addr));
    end
  endfunction

  // decoded register window; any other address is refused with pslverr
  function automatic logic mapped(input logic [pwc_pkg::ADDR_W-1:0] addr);
    mapped = (addr == pwc_pkg::OFS_TICK_DIVIDER_VALUE) || (addr == pwc_pkg::OFS_NOTIFY_CTL) ||
             in_bank(addr, pwc_pkg::OFS_CAPT_BASE) || in_bank(addr, pwc_pkg::OFS_PORTNUM_BASE);
  endfunction

  // apb phase decode; the slave never stretches the access phase
  // the error flag is decided in the setup cycle, so the access phase needs no decode
  assign setup_phase = psel && !penable;
  assign apb_write   = psel && penable && pwrite && pready;
  assign ctl_write   = apb_write && pstrb[0] && (paddr == pwc_pkg::OFS_NOTIFY_CTL);
  assign flag_clear  = ctl_write && pwdata[pwc_pkg::FLAG_BIT];

  // next-state logic for every register of the block
  always_comb begin
    next_st           = st;
    next_st.out_valid = 1'b0;

    // tick_divider_value write; only byte lane 0 holds live bits, upper lanes are ignored
    if (apb_write && pstrb[0] && (paddr == pwc_pkg::OFS_TICK_DIVIDER_VALUE)) begin
      next_st.tick_divider_value = pwdata[pwc_pkg::TICK_DIVIDER_VALUE_MSB:0];
    end
    // enable follows bit 1 of every control write; bit 0 only ever clears
    if (ctl_write) begin
      next_st.notify_in_irq_enable = pwdata[pwc_pkg::EN_BIT];
    end

    // sticky flag: a payload arriving with the clearing write still sets it
    next_st.notify_in_flag = (st.notify_in_flag && !flag_clear) || pw_in_valid;
    if (pw_in_valid) begin
      next_st.notify_payload_word = pw_in_payload;
    end

    // read data is taken in the setup cycle so prdata leaves a flip-flop
    if (setup_phase) begin
      next_st.rd_data = pwrite ? pwc_pkg::WORD_ZERO : read_word(paddr, st);
      next_st.rd_err  = !mapped(paddr);
    end

    // outgoing port-write: report this port's own number
    // a request every cycle is fine: each one reloads the number
    if (pw_out_req) begin
      next_st.out_valid  = 1'b1;
      next_st.out_number = switch_port_number(pw_out_port);
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                    <= '0;
      st.tick_divider_value <= pwc_pkg::TICK_DIVIDER_VALUE_RST;
    end else begin
      st <= next_st;
    end
  end

  // time base; the divider value itself is software's to pick per clock rate
  assign tif.divider = st.tick_divider_value;

  pwc_tick_gen u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif)
  );

  // outputs
  // every register is a flop or a constant, so the slave never needs a wait state
  assign prdata             = st.rd_data;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && st.rd_err;
  assign pw_out_valid       = st.out_valid;
  assign pw_out_port_number = st.out_number;
  assign notify_in_irq_out  = st.notify_in_flag && st.notify_in_irq_enable;
  assign tick_out           = tif.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write(logic [pwc_pkg::ADDR_W-1:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence

  sequence s_read_setup(logic [pwc_pkg::ADDR_W-1:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  AST_TICK_DIVIDER_VALUE_WRITE: assert property (s_write(pwc_pkg::OFS_TICK_DIVIDER_VALUE) |=>
      st.tick_divider_value == $past(pwdata[pwc_pkg::TICK_DIVIDER_VALUE_MSB:0]))
    else $error("tick_divider_value write not stored");

  AST_TICK_DIVIDER_VALUE_READBACK: assert property (s_read_setup(pwc_pkg::OFS_TICK_DIVIDER_VALUE) |=>
      prdata == {24'h00_0000, $past(st.tick_divider_value)})
    else $error("tick_divider_value read wrong or reserved bits set");

  AST_CAPTURE: assert property (pw_in_valid |=>
      st.notify_payload_word == $past(pw_in_payload))
    else $error("payload not captured");

  AST_CAPT_READ: assert property ((s_read_setup(pwc_pkg::OFS_CAPT_BASE + 12'h008) ##1
      (psel && penable)) |-> prdata == $past(st.notify_payload_word[2]))
    else $error("capture word 2 read wrong");

  AST_FLAG_SET: assert property (pw_in_valid |=> st.notify_in_flag)
    else $error("flag not set by payload");

  AST_FLAG_STICKY: assert property ((st.notify_in_flag && !flag_clear) |=> st.notify_in_flag)
    else $error("flag dropped without clear");

  AST_FLAG_CLEAR: assert property ((flag_clear && !pw_in_valid) |=> !st.notify_in_flag)
    else $error("flag not cleared by write of one");

  AST_IRQ_MASKED: assert property (!st.notify_in_irq_enable |-> !notify_in_irq_out)
    else $error("interrupt while disabled");

  AST_IRQ_FOLLOWS: assert property ((pw_in_valid && st.notify_in_irq_enable && !ctl_write)
      |=> notify_in_irq_out)
    else $error("interrupt missing after payload");

  AST_PORTNUM_READ: assert property ((s_read_setup(pwc_pkg::OFS_PORTNUM_BASE + 12'h00C) ##1
      (psel && penable)) |-> prdata == {24'h00_0000, SWITCH_BLOCK, 2'h3})
    else $error("port number read wrong");

  AST_PWOUT_NUMBER: assert property (pw_out_req |=>
      pw_out_valid && pw_out_port_number == {SWITCH_BLOCK, $past(pw_out_port)})
    else $error("outgoing port number wrong");

  // one access phase of any transfer
  sequence s_access;
    psel && penable;
  endsequence

  // setup cycle whose address is (m=1) or is not (m=0) a mapped register
  sequence s_setup_at(logic m);
    psel && !penable && (mapped(paddr) == m);
  endsequence

  // read setup at any word-aligned address inside a four-word bank
  sequence s_read_bank(logic [pwc_pkg::ADDR_W-1:0] base);
    psel && !penable && !pwrite && in_bank(paddr, base);
  endsequence

  // the low end of each bank pins down the word index
  AST_CAPT_READ0: assert property ((s_read_setup(pwc_pkg::OFS_CAPT_BASE) ##1 s_access) |->
      prdata == $past(st.notify_payload_word[0]))
    else $error("capture word 0 read wrong");

  AST_PORTNUM_READ0: assert property ((s_read_setup(pwc_pkg::OFS_PORTNUM_BASE) ##1 s_access) |->
      prdata == {24'h00_0000, SWITCH_BLOCK, 2'h0})
    else $error("port number 0 read wrong");

  // every word of both banks answers with its own index
  AST_CAPT_ANY: assert property ((s_read_bank(pwc_pkg::OFS_CAPT_BASE) ##1 s_access) |->
      prdata == $past(st.notify_payload_word[bank_idx(paddr)]))
    else $error("capture word read from wrong index");

  AST_PORTNUM_ANY: assert property ((s_read_bank(pwc_pkg::OFS_PORTNUM_BASE) ##1 s_access) |->
      prdata == {24'h00_0000, SWITCH_BLOCK, $past(paddr[pwc_pkg::IDX_MSB:pwc_pkg::IDX_LSB])})
    else $error("port number read from wrong index");

  // control word readback: flag in bit 0, enable in bit 1, the rest zero
  AST_NOTIFY_READBACK: assert property (s_read_setup(pwc_pkg::OFS_NOTIFY_CTL) |=>
      prdata[pwc_pkg::FLAG_BIT] == $past(st.notify_in_flag) &&
      prdata[pwc_pkg::EN_BIT] == $past(st.notify_in_irq_enable) &&
      prdata[pwc_pkg::DATA_W-1:pwc_pkg::EN_BIT+1] == '0)
    else $error("control word read wrong");

  // unmapped addresses answer with an error and zero data
  AST_UNMAPPED_ERR: assert property ((s_setup_at(1'b0) ##1 s_access) |->
      pslverr && prdata == pwc_pkg::WORD_ZERO)
    else $error("unmapped access not refused");

  // read-only registers take writes without an error
  AST_MAPPED_OK: assert property ((s_setup_at(1'b1) ##1 s_access) |-> !pslverr)
    else $error("error on a mapped register");

  // read data stands until the next setup cycle
  AST_RD_HOLD: assert property (!setup_phase |=> $stable(prdata))
    else $error("read data moved outside a setup cycle");

  // software cannot reach the captures; only a received payload moves them
  AST_CAPT_HOLD: assert property (!pw_in_valid |=> $stable(st.notify_payload_word))
    else $error("capture changed without a payload");

  // the tick_divider_value only moves on a write with byte lane 0 on
  AST_TICK_DIVIDER_VALUE_HOLD: assert property (!(apb_write && pstrb[0] && paddr == pwc_pkg::OFS_TICK_DIVIDER_VALUE) |=>
      $stable(st.tick_divider_value))
    else $error("tick_divider_value changed without a write");

  AST_ENABLE_HOLD: assert property (!ctl_write |=> $stable(st.notify_in_irq_enable))
    else $error("enable changed without a write");

  // a payload beats a clearing write in the same cycle
  AST_FLAG_SET_WINS: assert property ((pw_in_valid && flag_clear) |=> st.notify_in_flag)
    else $error("clear beat a new payload");

  // the interrupt drops after a clear or a disable
  AST_IRQ_DROP: assert property ((flag_clear && !pw_in_valid) |=> !notify_in_irq_out)
    else $error("interrupt stayed after clear");

  AST_IRQ_DISABLE: assert property ((ctl_write && !pwdata[pwc_pkg::EN_BIT]) |=> !notify_in_irq_out)
    else $error("interrupt stayed after disable");

  // the outgoing strobe lasts one cycle and the number holds between requests
  AST_PWOUT_ONE_CYCLE: assert property (!pw_out_req |=> !pw_out_valid)
    else $error("outgoing valid without request");

  AST_PWOUT_HOLD: assert property (!pw_out_req |=> $stable(pw_out_port_number))
    else $error("outgoing number moved without request");

endmodule

/* pwc_tick_gen.sv */
/*
  Time-base generator: divides pclk by (divider + 1) into a one-cycle tick.
  Assumes the divider comes from a register on the same clock.
*/
module pwc_tick_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  pwc_tick_if.gen   tif
);

  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } pwc_tick_state_t;

  pwc_tick_state_t st;
  pwc_tick_state_t next_st;

  // count up to the divider; >= keeps a lowered divider from wrapping through 255
  always_comb begin
    next_st = st;
    if (st.count >= tif.divider) begin
      next_st.count = pwc_pkg::BYTE_ZERO;
      next_st.tick  = 1'b1;
    end else begin
      next_st.count = 8'(st.count + 8'h01);
      next_st.tick  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tif.tick = st.tick; // from a flip-flop

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a tick only follows a full count to the divider
  AST_TICK_AT_TERMINAL: assert property (tif.tick |-> $past(st.count) >= $past(tif.divider))
    else $error("tick without terminal count");
  // with divider above zero two ticks never sit back to back
  AST_TICK_SPACED: assert property ((tif.tick && tif.divider != 8'h00) |=> !tif.tick)
    else $error("ticks too close");

endmodule

/* pwc_tick_if.sv */
/*
  Interface carrying the tick divider value to the time-base generator and the
  tick enable back.
  Assumes both ends run on pclk.
*/
interface pwc_tick_if;
  logic [7:0] divider;
  logic       tick;

  modport cfg (output divider, input tick);
  modport gen (input divider, output tick);
endinterface
